/* File: logic/sccr_dac_clamp.sv */
// DAC output code stage with clamp limits
`timescale 1ns/1ps
module sccr_dac_clamp
  import sccr_pkg::*;
(
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset_n,
  input  wire logic [7:0]       i_clamp_high_code,
  input  wire logic [7:0]       i_clamp_low_code,
  input  wire logic             i_bypass,
  input  wire logic             i_load,
  input  wire logic [DAC_W-1:0] i_code,
  output logic      [DAC_W-1:0] o_code
);

  // ****************************************
  // Limits in DAC codes
  // ****************************************
  wire logic [DAC_W:0]   hi_raw;
  wire logic [DAC_W-1:0] lim_hi;
  wire logic [DAC_W-1:0] lim_lo;
  wire logic [DAC_W-1:0] clamped;
  logic      [DAC_W-1:0] code_q;
  logic      [DAC_W-1:0] code_d;

  assign hi_raw  = {1'b1, {DAC_W{1'b0}}}
                 - {{(DAC_W+1-8-CLAMP_SHIFT){1'b0}}, i_clamp_high_code,
                    {CLAMP_SHIFT{1'b0}}};
  assign lim_hi  = hi_raw[DAC_W] ? {DAC_W{1'b1}} : hi_raw[DAC_W-1:0];
  assign lim_lo  = {{(DAC_W-8-CLAMP_SHIFT){1'b0}}, i_clamp_low_code,
                    {CLAMP_SHIFT{1'b0}}};
  assign clamped = (i_code > lim_hi) ? lim_hi :
                   (i_code < lim_lo) ? lim_lo : i_code;
  assign code_d  = !i_load ? code_q : (i_bypass ? i_code : clamped);
  assign o_code  = code_q;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      code_q <= RST_DAC;
    end else begin
      code_q <= code_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_clamp_range: assert property (
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_load && !i_bypass) |=> (code_q <= $past(lim_hi)) && (code_q >= $past(lim_lo)))
    else $error("calibrated DAC code outside clamp limits");

  chk_clamp_high: assert property (
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_load && !i_bypass && i_code == {DAC_W{1'b1}} && i_clamp_high_code != 8'h00)
    |=> code_q == DAC_W'(32'h10000 - ({24'h0, $past(i_clamp_high_code)} << CLAMP_SHIFT)))
    else $error("high clamp level wrong");

  chk_clamp_low: assert property (
    @(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_load && !i_bypass && i_code == {DAC_W{1'b0}})
    |=> code_q == {1'b0, $past(i_clamp_low_code), 7'h00})
    else $error("low clamp level wrong");

endmodule

/* File: logic/sccr_pkg.sv */
// Package: register indices, field positions, reset values and widths
package sccr_pkg;

  // ****************************************
  // Register indices (byte address = 4 * index)
  // ****************************************
  localparam int                IDX_W        = 10;
  localparam logic [IDX_W-1:0]  IDX_CAL_MODE = 10'h0A1;
  localparam logic [IDX_W-1:0]  IDX_PCFG     = 10'h0A5;
  localparam logic [IDX_W-1:0]  IDX_TCFG     = 10'h0A6;
  localparam logic [IDX_W-1:0]  IDX_CLMP_H   = 10'h0A7;
  localparam logic [IDX_W-1:0]  IDX_CLMP_L   = 10'h0A8;
  localparam logic [IDX_W-1:0]  IDX_REF_OFFSET_COEF_H   = 10'h0A9;
  localparam logic [IDX_W-1:0]  IDX_REF_OFFSET_COEF_L   = 10'h0AA;
  localparam logic [IDX_W-1:0]  IDX_TC1_H    = 10'h0AB;
  localparam logic [IDX_W-1:0]  IDX_TC1_L    = 10'h0AC;
  localparam logic [IDX_W-1:0]  IDX_TC2_H    = 10'h0AD;
  localparam logic [IDX_W-1:0]  IDX_TC2_L    = 10'h0AE;
  localparam logic [IDX_W-1:0]  IDX_PRES     = 10'h0D0;
  localparam logic [IDX_W-1:0]  IDX_TRES     = 10'h0D1;
  localparam logic [IDX_W-1:0]  IDX_DAC_EXT  = 10'h0D2;
  localparam logic [IDX_W-1:0]  IDX_DAC_OUT  = 10'h0D3;
  localparam int                BYTE_NUM     = 10;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int P_REF_HI   = 7;
  localparam int P_REF_LO   = 6;
  localparam int P_CHOP     = 2;
  localparam int P_SWAP     = 1;
  localparam int P_RAW      = 0;
  localparam int T_SRC      = 7;
  localparam int T_GAIN_HI  = 6;
  localparam int T_GAIN_LO  = 5;
  localparam int T_RATE_HI  = 4;
  localparam int T_RATE_LO  = 1;
  localparam int T_RAW      = 0;
  localparam int C_MODE_BIT = 7;

  // ****************************************
  // Reset values and constants
  // ****************************************
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic        RST_CAL_MODE  = 1'b0;
  localparam logic [15:0] RST_DAC       = 16'h0000;
  localparam logic [23:0] RST_RESULT    = 24'h000000;
  localparam logic [3:0]  RATE_OFF_MIN  = 4'hE;
  localparam logic [2:0]  PCFG_RSVD_VAL = 3'h0;
  localparam int          DAC_W         = 16;
  localparam int          CLAMP_SHIFT   = 7;
  localparam logic [4:0]  LSB_EXP_FIRST = 5'h16;
  localparam logic [4:0]  LSB_EXP_SQ    = 5'h1D;

  typedef enum logic [1:0] {GAIN_1X, GAIN_2X, GAIN_4X} sccr_gain_t;

endpackage

/* File: logic/sccr_regs.sv */
// Sensor channel configuration registers with APB access
`timescale 1ns/1ps

// Behaviour
// - Bits 7-6 of the primary config select DAC full scale: 5 V, 3.3 V, 1.2 V, analog supply.
// - Bit 2 of the primary config turns system chopping on or off.
// - Bit 1 of the primary config swaps the polarity of the primary converter inputs.
// - With bit 0 clear, calibrated results fill the primary result and calibration sets DAC.
// - With bit 0 set, raw converter results fill the primary result and the DAC is external.
// - Bit 7 of the temperature config picks the internal (0) or external pin (1) sensor.
// - Bits 6-5 of the temperature config set gain 1X, 2X, 4X, with code 11 also 4X.
// - Bits 4-1 set the temperature rate like the primary rate, codes 14 and 15 turn it off.
// - While the temperature converter is off, the negative reference comes from the pin.
// - Bit 0 of the temperature config stores raw (1) or calibrated (0) temperature data.
// - The high clamp code sets the upper limit to full scale times one minus code/512.
// - The low clamp code sets the lower limit to full scale times code/512.
// - The reference offset is 16 bits, upper byte at 0xA9, lower at 0xAA.
// - The first offset tempco is 16 bits with LSB 2^-22 in either calibration mode.
// - The second offset tempco has LSB 2^-29 in single segment mode, 2^-22 in two segment.
// - The calibration mode bit picks single segment (0) or two segment (1) calibration.
module sccr_regs
  import sccr_pkg::*;
#(
  parameter int DATA_W = 24
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_reset_n,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [11:0]       i_paddr,
  input  wire logic [31:0]       i_pwdata,
  input  wire logic [3:0]        i_pstrb,
  output logic                   o_pready,
  output logic      [31:0]       o_prdata,
  output logic                   o_pslverr,
  input  wire logic              i_pconv_valid,
  input  wire logic [DATA_W-1:0] i_pconv_data,
  input  wire logic              i_pcal_valid,
  input  wire logic [DATA_W-1:0] i_pcal_data,
  input  wire logic              i_tconv_valid,
  input  wire logic [DATA_W-1:0] i_tconv_data,
  input  wire logic              i_tcal_valid,
  input  wire logic [DATA_W-1:0] i_tcal_data,
  input  wire logic              i_cal_dac_valid,
  input  wire logic [DAC_W-1:0]  i_cal_dac_code,
  output logic      [1:0]        o_dac_ref_sel,
  output logic                   o_chop_en,
  output logic                   o_input_swap,
  output logic                   o_temp_source_ext,
  output sccr_gain_t             o_temp_gain,
  output logic      [3:0]        o_temp_rate,
  output logic                   o_temp_conv_en,
  output logic                   o_negative_reference_from_pin,
  output logic                   o_cal_two_segment,
  output logic      [15:0]       o_ref_offset_coef,
  output logic      [15:0]       o_offset_tempco_first,
  output logic      [15:0]       o_offset_tempco_second,
  output logic      [4:0]        o_second_lsb_exp,
  output logic      [DATA_W-1:0] o_primary_result,
  output logic      [DATA_W-1:0] o_temp_result,
  output logic      [DAC_W-1:0]  o_dac_code
);

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic idx_hit(input logic [11:0] addr, input logic [IDX_W-1:0] idx);
    idx_hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  function automatic sccr_gain_t gain_decode(input logic [1:0] code);
    gain_decode = (code == 2'b00) ? GAIN_1X : (code == 2'b01) ? GAIN_2X : GAIN_4X;
  endfunction

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0]        byte_q [BYTE_NUM];
  logic              cal_mode_q;
  logic [DAC_W-1:0]  dac_ext_q;
  logic [DATA_W-1:0] pres_q;
  logic [DATA_W-1:0] pres_d;
  logic [DATA_W-1:0] tres_q;
  logic [DATA_W-1:0] tres_d;
  logic [31:0]       prdata_q;
  logic [31:0]       prdata_d;
  logic              pslverr_q;

  wire logic              wr_acc;
  wire logic              setup;
  wire logic [IDX_W-1:0]  idx;
  wire logic [IDX_W-1:0]  byte_off;
  wire logic              hit_byte;
  wire logic              hit_mode;
  wire logic              hit_pres;
  wire logic              hit_tres;
  wire logic              hit_dext;
  wire logic              hit_dout;
  wire logic              mapped;
  wire logic [7:0]        pcfg;
  wire logic [7:0]        tcfg;
  wire logic              raw_p;
  wire logic              raw_t;
  wire logic [DAC_W-1:0]  dac_src;
  wire logic              dac_load;
  wire logic [7:0]        byte_rd;

  // ****************************************
  // APB decode
  // ****************************************
  assign setup    = i_psel && !i_penable;
  assign wr_acc   = i_psel && i_penable && i_pwrite;
  assign idx      = i_paddr[11:2];
  assign byte_off = idx - IDX_PCFG;
  assign hit_byte = (i_paddr[1:0] == 2'b00) && (idx >= IDX_PCFG) && (idx <= IDX_TC2_L);
  assign hit_mode = idx_hit(i_paddr, IDX_CAL_MODE);
  assign hit_pres = idx_hit(i_paddr, IDX_PRES);
  assign hit_tres = idx_hit(i_paddr, IDX_TRES);
  assign hit_dext = idx_hit(i_paddr, IDX_DAC_EXT);
  assign hit_dout = idx_hit(i_paddr, IDX_DAC_OUT);
  assign mapped   = hit_byte || hit_mode || hit_pres || hit_tres || hit_dext || hit_dout;
  assign byte_rd  = hit_byte ? byte_q[byte_off[3:0]] : 8'h00;

  always_comb begin
    if (hit_byte) begin
      prdata_d = {24'h000000, byte_rd};
    end else if (hit_mode) begin
      prdata_d = {24'h000000, cal_mode_q, 7'h00};
    end else if (hit_pres) begin
      prdata_d = 32'(pres_q);
    end else if (hit_tres) begin
      prdata_d = 32'(tres_q);
    end else if (hit_dext) begin
      prdata_d = {16'h0000, dac_ext_q};
    end else if (hit_dout) begin
      prdata_d = {16'h0000, o_dac_code};
    end else begin
      prdata_d = 32'h00000000;
    end
  end

  // Answer is taken in the setup cycle so the access phase ends at once
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= i_pwrite ? 32'h00000000 : prdata_d;
      pslverr_q <= !mapped;
    end
  end

  assign o_pready  = i_psel && i_penable;
  assign o_prdata  = prdata_q;
  assign o_pslverr = o_pready && pslverr_q;

  // ****************************************
  // Configuration and coefficient bytes
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < BYTE_NUM; g++) begin : g_byte
      always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
          byte_q[g] <= RST_BYTE;
        end else if (wr_acc && hit_byte && i_pstrb[0] && byte_off == IDX_W'(g)) begin
          byte_q[g] <= (g == 0) ? {i_pwdata[7:6], PCFG_RSVD_VAL, i_pwdata[2:0]}
                                : i_pwdata[7:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cal_mode_q <= RST_CAL_MODE;
    end else if (wr_acc && hit_mode && i_pstrb[0]) begin
      cal_mode_q <= i_pwdata[C_MODE_BIT];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dac_ext_q <= RST_DAC;
    end else if (wr_acc && hit_dext) begin
      dac_ext_q <= {i_pstrb[1] ? i_pwdata[15:8] : dac_ext_q[15:8],
                    i_pstrb[0] ? i_pwdata[7:0] : dac_ext_q[7:0]};
    end
  end

  // ****************************************
  // Channel controls
  // ****************************************
  assign pcfg              = byte_q[0];
  assign tcfg              = byte_q[1];
  assign raw_p             = pcfg[P_RAW];
  assign raw_t             = tcfg[T_RAW];
  assign o_dac_ref_sel     = pcfg[P_REF_HI:P_REF_LO];
  assign o_chop_en         = pcfg[P_CHOP];
  assign o_input_swap      = pcfg[P_SWAP];
  assign o_temp_source_ext = tcfg[T_SRC];
  assign o_temp_gain       = gain_decode(tcfg[T_GAIN_HI:T_GAIN_LO]);
  assign o_temp_rate       = tcfg[T_RATE_HI:T_RATE_LO];
  assign o_temp_conv_en    = o_temp_rate < RATE_OFF_MIN;
  assign o_negative_reference_from_pin  = !o_temp_conv_en;
  assign o_cal_two_segment = cal_mode_q;

  // ****************************************
  // Calibration coefficients
  // ****************************************
  assign o_ref_offset_coef      = {byte_q[4], byte_q[5]};
  assign o_offset_tempco_first  = {byte_q[6], byte_q[7]};
  assign o_offset_tempco_second = {byte_q[8], byte_q[9]};
  assign o_second_lsb_exp       = cal_mode_q ? LSB_EXP_FIRST : LSB_EXP_SQ;

  // ****************************************
  // Result capture
  // ****************************************
  assign pres_d = raw_p ? (i_pconv_valid ? i_pconv_data : pres_q)
                        : (i_pcal_valid ? i_pcal_data : pres_q);
  assign tres_d = raw_t ? (i_tconv_valid ? i_tconv_data : tres_q)
                        : (i_tcal_valid ? i_tcal_data : tres_q);

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pres_q <= DATA_W'(RST_RESULT);
      tres_q <= DATA_W'(RST_RESULT);
    end else begin
      pres_q <= pres_d;
      tres_q <= tres_d;
    end
  end

  assign o_primary_result = pres_q;
  assign o_temp_result    = tres_q;

  // ****************************************
  // DAC source and clamp
  // ****************************************
  assign dac_src  = raw_p ? dac_ext_q : i_cal_dac_code;
  assign dac_load = raw_p || i_cal_dac_valid;

  sccr_dac_clamp u_clamp (
    .i_clk_sys         (i_clk_sys),
    .i_reset_n         (i_reset_n),
    .i_clamp_high_code (byte_q[2]),
    .i_clamp_low_code  (byte_q[3]),
    .i_bypass          (raw_p),
    .i_load            (dac_load),
    .i_code            (dac_src),
    .o_code            (o_dac_code)
  );

  // ****************************************
  // Checks
  // ****************************************
  chk_dac_ref_wr: assert property (
    (wr_acc && i_pstrb[0] && idx_hit(i_paddr, IDX_PCFG))
    |=> o_dac_ref_sel == $past(i_pwdata[7:6]))
    else $error("DAC reference field not taken from write");

  chk_chop_swap: assert property (
    (wr_acc && i_pstrb[0] && idx_hit(i_paddr, IDX_PCFG))
    |=> (o_chop_en == $past(i_pwdata[2])) && (o_input_swap == $past(i_pwdata[1])))
    else $error("chopping or swap bit not taken from write");

  chk_swap_hold: assert property (
    !(wr_acc && idx_hit(i_paddr, IDX_PCFG)) |=> $stable(o_input_swap))
    else $error("input swap changed without a write");

  chk_raw_primary: assert property (
    (raw_p && i_pconv_valid) |=> o_primary_result == $past(i_pconv_data))
    else $error("raw primary result not stored");

  chk_cal_primary: assert property (
    (!raw_p && i_pcal_valid) |=> o_primary_result == $past(i_pcal_data))
    else $error("calibrated primary result not stored");

  chk_dac_external: assert property (
    (raw_p && !(wr_acc && hit_byte)) ##1 raw_p |-> o_dac_code == $past(dac_ext_q))
    else $error("external DAC value not driven");

  chk_temp_source: assert property (
    (wr_acc && i_pstrb[0] && idx_hit(i_paddr, IDX_TCFG))
    |=> o_temp_source_ext == $past(i_pwdata[7]))
    else $error("temperature source not taken from write");

  chk_temp_gain: assert property (
    (tcfg[T_GAIN_HI] |-> o_temp_gain == GAIN_4X)
    and (tcfg[T_GAIN_HI:T_GAIN_LO] == 2'b01 |-> o_temp_gain == GAIN_2X))
    else $error("temperature gain decode wrong");

  chk_temp_off: assert property (
    (tcfg[4:3] == 2'b11 && tcfg[2]) |-> (!o_temp_conv_en && o_negative_reference_from_pin))
    else $error("temperature converter not disabled");

  chk_temp_raw: assert property (
    (raw_t && i_tconv_valid) |=> o_temp_result == $past(i_tconv_data))
    else $error("raw temperature result not stored");

  chk_offset_coef: assert property (
    (wr_acc && i_pstrb[0] && idx_hit(i_paddr, IDX_REF_OFFSET_COEF_H))
    |=> o_ref_offset_coef[15:8] == $past(i_pwdata[7:0]))
    else $error("offset upper byte not stored");

  chk_second_lsb: assert property (
    (wr_acc && i_pstrb[0] && hit_mode && i_pwdata[7])
    |=> o_second_lsb_exp == 5'h16 && o_cal_two_segment)
    else $error("second tempco scale wrong in two segment mode");

  chk_temp_cal: assert property (
    (!raw_t && i_tcal_valid) |=> o_temp_result == $past(i_tcal_data))
    else $error("calibrated temperature result not stored");

  chk_offset_low: assert property (
    (wr_acc && i_pstrb[0] && idx_hit(i_paddr, IDX_REF_OFFSET_COEF_L))
    |=> o_ref_offset_coef[7:0] == $past(i_pwdata[7:0]))
    else $error("offset lower byte not stored");

  chk_tempco_first: assert property (
    (wr_acc && i_pstrb[0] && idx_hit(i_paddr, IDX_TC1_H))
    |=> o_offset_tempco_first[15:8] == $past(i_pwdata[7:0]))
    else $error("first tempco upper byte not stored");

  chk_temp_rate: assert property (
    (wr_acc && i_pstrb[0] && idx_hit(i_paddr, IDX_TCFG))
    |=> o_temp_rate == $past(i_pwdata[4:1]))
    else $error("temperature rate not taken from write");

  chk_dac_hold: assert property (
    (!raw_p && !i_cal_dac_valid) |=> $stable(o_dac_code))
    else $error("DAC code changed without a calibration update");

endmodule

/* File: verification/tb.sv */
// Self-checking testbench for the sensor channel configuration registers
`timescale 1ns/1ps
module tb
  import sccr_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  logic             i_clk_sys = 1'b0;
  logic             i_reset_n, i_psel, i_penable, i_pwrite;
  logic [11:0]      i_paddr;
  logic [31:0]      i_pwdata, o_prdata, last_rd;
  logic [3:0]       i_pstrb, o_temp_rate;
  logic             i_pconv_valid, i_pcal_valid, i_tconv_valid, i_tcal_valid, i_cal_dac_valid;
  logic [23:0]      i_pconv_data, i_pcal_data, i_tconv_data, i_tcal_data;
  logic [23:0]      o_primary_result, o_temp_result;
  logic [DAC_W-1:0] i_cal_dac_code, o_dac_code;
  logic             o_pready, o_pslverr, o_chop_en, o_input_swap, o_temp_source_ext;
  logic             o_temp_conv_en, o_negative_reference_from_pin, o_cal_two_segment, last_err;
  logic [1:0]       o_dac_ref_sel;
  sccr_gain_t       o_temp_gain;
  logic [15:0]      o_ref_offset_coef, o_offset_tempco_first, o_offset_tempco_second;
  logic [4:0]       o_second_lsb_exp;
  int               num_errors, checks, c, k;
  logic [9:0]       regs [11];
  logic [15:0]      dcodes [7];
  sccr_gain_t       exp_g [4];

  sccr_regs i_dut (
    .i_clk_sys, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb,
    .o_pready, .o_prdata, .o_pslverr, .i_pconv_valid, .i_pconv_data, .i_pcal_valid,
    .i_pcal_data, .i_tconv_valid, .i_tconv_data, .i_tcal_valid, .i_tcal_data,
    .i_cal_dac_valid, .i_cal_dac_code, .o_dac_ref_sel, .o_chop_en, .o_input_swap,
    .o_temp_source_ext, .o_temp_gain, .o_temp_rate, .o_temp_conv_en, .o_negative_reference_from_pin,
    .o_cal_two_segment, .o_ref_offset_coef, .o_offset_tempco_first,
    .o_offset_tempco_second, .o_second_lsb_exp, .o_primary_result, .o_temp_result,
    .o_dac_code
  );

  always #4 i_clk_sys = ~i_clk_sys;

  // ****************************************
  // Compare and bus tasks
  // ****************************************
  task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_flag(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge i_clk_sys);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= wr_en;
    i_paddr   <= a;
    i_pwdata  <= d;
    i_pstrb   <= s;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_pready !== 1'b1 && n < 16);
    chk_flag("pready", 1'b1, o_pready);
    last_rd  = o_prdata;
    last_err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    apb(1'b1, {idx, 2'b00}, d, 4'hF);
    @(negedge i_clk_sys);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, {idx, 2'b00}, 32'h0, 4'h0);
    chk_val("prdata", exp, last_rd);
    chk_flag("pslverr", 1'b0, last_err);
  endtask

  task automatic pulse(input int which, input logic [23:0] d);
    @(posedge i_clk_sys);
    i_pconv_valid   <= (which == 0);
    i_pcal_valid    <= (which == 1);
    i_tconv_valid   <= (which == 2);
    i_tcal_valid    <= (which == 3);
    i_cal_dac_valid <= (which == 4);
    i_pconv_data    <= d;
    i_pcal_data     <= d;
    i_tconv_data    <= d;
    i_tcal_data     <= d;
    i_cal_dac_code  <= d[15:0];
    @(posedge i_clk_sys);
    {i_pconv_valid, i_pcal_valid, i_tconv_valid, i_tcal_valid, i_cal_dac_valid} <= 5'h00;
    @(negedge i_clk_sys);
  endtask

  function automatic logic [7:0] pat(input int i);
    return 8'(i * 37 + 5);
  endfunction

  function automatic logic [31:0] clamp_exp(input int code, input int ch, input int cl);
    int lo, hi;
    lo = cl * 128;
    hi = 65536 - ch * 128;
    if (hi > 65535) hi = 65535;
    if (code < lo) return 32'(lo);
    if (code > hi) return 32'(hi);
    return 32'(code);
  endfunction

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk_sys);
    num_errors++;
    finish_test;
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {i_reset_n, i_psel, i_penable, i_pwrite} = 4'h0;
    {i_pconv_valid, i_pcal_valid, i_tconv_valid, i_tcal_valid, i_cal_dac_valid} = 5'h00;
    {i_paddr, i_pwdata, i_pstrb} = '0;
    {i_pconv_data, i_pcal_data, i_tconv_data, i_tcal_data, i_cal_dac_code} = '0;
    regs = '{IDX_CAL_MODE, IDX_PCFG, IDX_TCFG, IDX_CLMP_H, IDX_CLMP_L, IDX_REF_OFFSET_COEF_H,
             IDX_REF_OFFSET_COEF_L, IDX_TC1_H, IDX_TC1_L, IDX_TC2_H, IDX_TC2_L};
    dcodes = '{16'h0000, 16'h0100, 16'h0800, 16'h8000, 16'hF000, 16'hF001, 16'hFFFF};
    exp_g = '{GAIN_1X, GAIN_2X, GAIN_4X, GAIN_4X};
    repeat (4) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    // Reset values
    foreach (regs[c]) rd(regs[c], 32'h0);
    chk_val("temp_gain", GAIN_1X, o_temp_gain);
    chk_flag("conv_en", 1'b1, o_temp_conv_en);
    chk_flag("negative_reference_pin", 1'b0, o_negative_reference_from_pin);
    chk_val("lsb_exp", 32'h1D, o_second_lsb_exp);
    // Byte registers, upper lanes not stored
    for (c = 3; c < 11; c++) wr(regs[c], {24'hFFFFFF, pat(c)});
    for (c = 3; c < 11; c++) rd(regs[c], {24'h0, pat(c)});
    chk_val("ref_offset", {pat(5), pat(6)}, o_ref_offset_coef);
    chk_val("tempco_1", {pat(7), pat(8)}, o_offset_tempco_first);
    chk_val("tempco_2", {pat(9), pat(10)}, o_offset_tempco_second);
    apb(1'b1, {IDX_CLMP_H, 2'b00}, 32'h0, 4'hE);
    rd(IDX_CLMP_H, {24'h0, pat(3)});
    // Unmapped and misaligned accesses
    apb(1'b0, 12'hFFC, 32'h0, 4'h0);
    chk_flag("pslverr", 1'b1, last_err);
    chk_val("prdata", 32'h0, last_rd);
    apb(1'b1, {IDX_CLMP_L, 2'b01}, 32'hFF, 4'hF);
    chk_flag("pslverr", 1'b1, last_err);
    rd(IDX_CLMP_L, {24'h0, pat(4)});
    // Calibration mode
    wr(IDX_CAL_MODE, 32'hFF);
    rd(IDX_CAL_MODE, 32'h80);
    chk_flag("two_seg", 1'b1, o_cal_two_segment);
    chk_val("lsb_exp", 32'h16, o_second_lsb_exp);
    wr(IDX_CAL_MODE, 32'h00);
    chk_flag("two_seg", 1'b0, o_cal_two_segment);
    chk_val("lsb_exp", 32'h1D, o_second_lsb_exp);
    // Primary configuration
    for (c = 0; c < 4; c++) begin
      wr(IDX_PCFG, 32'(c) << 6);
      chk_val("dac_ref", 32'(c), o_dac_ref_sel);
    end
    wr(IDX_PCFG, 32'h3A);
    rd(IDX_PCFG, 32'h02);
    chk_flag("chop", 1'b0, o_chop_en);
    chk_flag("swap", 1'b1, o_input_swap);
    wr(IDX_PCFG, 32'h04);
    chk_flag("chop", 1'b1, o_chop_en);
    chk_flag("swap", 1'b0, o_input_swap);
    // Temperature configuration
    for (c = 0; c < 4; c++) begin
      wr(IDX_TCFG, 32'h80 | (32'(c) << 5));
      chk_flag("temp_src", 1'b1, o_temp_source_ext);
      chk_val("temp_gain", exp_g[c], o_temp_gain);
    end
    for (c = 0; c < 16; c++) begin
      wr(IDX_TCFG, 32'(c) << 1);
      chk_flag("temp_src", 1'b0, o_temp_source_ext);
      chk_val("temp_rate", 32'(c), o_temp_rate);
      chk_flag("conv_en", c < 14, o_temp_conv_en);
      chk_flag("negative_reference_pin", c >= 14, o_negative_reference_from_pin);
    end
    // Result stores
    wr(IDX_PCFG, 32'h00);
    wr(IDX_TCFG, 32'h00);
    pulse(1, 24'h111111);
    pulse(0, 24'h222222);
    chk_val("primary", 32'h111111, o_primary_result);
    pulse(3, 24'h333333);
    pulse(2, 24'h444444);
    chk_val("temp", 32'h333333, o_temp_result);
    wr(IDX_PCFG, 32'h01);
    wr(IDX_TCFG, 32'h01);
    pulse(0, 24'h555555);
    pulse(1, 24'h666666);
    chk_val("primary", 32'h555555, o_primary_result);
    pulse(2, 24'h777777);
    pulse(3, 24'h888888);
    rd(IDX_TRES, 32'h777777);
    apb(1'b1, {IDX_PRES, 2'b00}, 32'hFFFFFF, 4'hF);
    chk_flag("pslverr", 1'b0, last_err);
    rd(IDX_PRES, 32'h555555);
    // External DAC code in raw mode
    apb(1'b1, {IDX_DAC_EXT, 2'b00}, 32'h1234, 4'h3);
    pulse(4, 24'h0);
    chk_val("dac_code", 32'h1234, o_dac_code);
    apb(1'b1, {IDX_DAC_EXT, 2'b00}, 32'hABCD, 4'h1);
    rd(IDX_DAC_EXT, 32'h12CD);
    rd(IDX_DAC_OUT, 32'h12CD);
    // Calibrated DAC code clamping
    wr(IDX_PCFG, 32'h00);
    for (k = 0; k < 2; k++) begin
      wr(IDX_CLMP_H, k ? 32'h20 : 32'h00);
      wr(IDX_CLMP_L, k ? 32'h10 : 32'h00);
      foreach (dcodes[c]) begin
        pulse(4, {8'h00, dcodes[c]});
        chk_val("dac_code", clamp_exp(dcodes[c], k * 32, k * 16), o_dac_code);
      end
    end
    rd(IDX_DAC_OUT, 32'hF000);
    finish_test;
  end
endmodule
